// *** logic/srp_pkg.sv ***
// constants and types for the segment relocation and protection unit
package srp_pkg;
  localparam int ADDR_W = 20;
  localparam int SEG_CNT = 16;
  localparam int SEG_IDX_W = 4;
  localparam int REG_W = 32;
  localparam int OFS_W = ADDR_W - SEG_IDX_W;
  localparam int GRAN_W = 8;
  localparam int BASE_W = ADDR_W - GRAN_W;
  localparam int LIM_W = OFS_W - GRAN_W;
  // segment register layout
  localparam int SEG_PRESENT_BIT = 31;
  localparam int SEG_NOEXEC_BIT = 30;
  localparam int SEG_WPROT_BIT = 29;
  localparam int SEG_BASE_LSB = 16;
  localparam int SEG_LIM_LSB = 0;
  localparam logic [REG_W-1:0] SEG_RESET = 32'h0000_0000;
  localparam logic [1:0] RST_SYNC_RESET = 2'h0;
  typedef enum logic [1:0] {
    SRP_SRC_NONE = 2'b00,
    SRP_SRC_CPU = 2'b01,
    SRP_SRC_DMA = 2'b10
  } srp_src_t;
endpackage

// *** logic/srp_xlat_if.sv ***
// lookup request and result between the unit and its translator
`timescale 1ns/1ps
`default_nettype none
interface srp_xlat_if;
  logic [srp_pkg::ADDR_W-1:0] log_addr;
  logic [srp_pkg::REG_W-1:0] seg_reg;
  logic is_fetch;
  logic is_write;
  logic [srp_pkg::ADDR_W-1:0] phys_addr;
  logic invalid;
  logic exec_viol;
  logic write_viol;
  modport unit (output log_addr, output seg_reg, output is_fetch, output is_write,
                input phys_addr, input invalid, input exec_viol, input write_viol);
  modport xlat (input log_addr, input seg_reg, input is_fetch, input is_write,
                output phys_addr, output invalid, output exec_viol, output write_viol);
endinterface
`default_nettype wire

// *** logic/srp_seg_xlat.sv ***
// combinational segment translation and protection check
`timescale 1ns/1ps
`default_nettype none
module srp_seg_xlat (
  srp_xlat_if.xlat x
);
  wire [srp_pkg::OFS_W-1:0] ofs = x.log_addr[srp_pkg::OFS_W-1:0];
  wire [srp_pkg::LIM_W-1:0] ofs_blk = ofs[srp_pkg::OFS_W-1:srp_pkg::GRAN_W];
  wire [srp_pkg::LIM_W-1:0] lim = x.seg_reg[srp_pkg::SEG_LIM_LSB +: srp_pkg::LIM_W];
  wire [srp_pkg::BASE_W-1:0] base = x.seg_reg[srp_pkg::SEG_BASE_LSB +: srp_pkg::BASE_W];
  wire present = x.seg_reg[srp_pkg::SEG_PRESENT_BIT];
  // limit counts 256-byte blocks minus one, so 256 bytes up to 64k
  wire over = ofs_blk > lim;
  wire [srp_pkg::ADDR_W-1:0] base_full = {base, {srp_pkg::GRAN_W{1'b0}}};
  // wraps past the top of the 1 MB space rather than faulting
  assign x.phys_addr = base_full + {{srp_pkg::SEG_IDX_W{1'b0}}, ofs};
  assign x.invalid = !present || over;
  assign x.exec_viol = x.is_fetch && x.seg_reg[srp_pkg::SEG_NOEXEC_BIT];
  assign x.write_viol = x.is_write && x.seg_reg[srp_pkg::SEG_WPROT_BIT];
endmodule // srp_seg_xlat
`default_nettype wire

// *** logic/srp_segment_relocation_protect.sv ***
// address guard unit: segment relocation and protection between core and memory
`timescale 1ns/1ps
`default_nettype none
// Operation
// - check and translate every user-mode address
// - map 20-bit logical onto 20-bit physical
// - flag addresses outside mapped region invalid
// - block fetches from non-executable segments
// - refuse writes to write-protected segments
// - up to sixteen independently mapped segments
// - segment base aligned on 256 bytes
// - segment length 256 bytes to 64K
// - supervisor mode bypasses translation and checks
// - direct memory bus transfers stay untranslated
// - sixteen 32-bit relocation registers
module srp_segment_relocation_protect (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // segment register load and readback port
  input wire logic seg_wr_en,
  input wire logic [srp_pkg::SEG_IDX_W-1:0] seg_wr_idx,
  input wire logic [srp_pkg::REG_W-1:0] seg_wr_data,
  input wire logic [srp_pkg::SEG_IDX_W-1:0] seg_rd_idx,
  output logic [srp_pkg::REG_W-1:0] seg_rd_data,
  // processor request
  input wire logic cpu_valid,
  input wire logic [srp_pkg::ADDR_W-1:0] cpu_addr,
  input wire logic cpu_write,
  input wire logic cpu_fetch,
  input wire logic cpu_user_mode,
  // direct_memory_io_bus request
  input wire logic dma_valid,
  input wire logic [srp_pkg::ADDR_W-1:0] dma_addr,
  input wire logic dma_write,
  // memory side
  output logic mem_valid,
  output logic [srp_pkg::ADDR_W-1:0] mem_addr,
  output logic mem_write,
  output logic [1:0] mem_src,
  // processor answer
  output logic cpu_retry,
  output logic fault,
  output logic fault_invalid,
  output logic fault_exec,
  output logic fault_write,
  output logic [srp_pkg::ADDR_W-1:0] fault_addr
);
  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  // ce stalls the release too, so enable must run for reset to end
  logic [1:0] rst_sync_r;
  wire rst_n = rst_sync_r[1];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_r <= srp_pkg::RST_SYNC_RESET;
    end else if (ce) begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  // ------------------------------------------------------------
  // relocation registers
  // ------------------------------------------------------------
  logic [srp_pkg::REG_W-1:0] seg_r [srp_pkg::SEG_CNT];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < srp_pkg::SEG_CNT; i++) begin
        seg_r[i] <= srp_pkg::SEG_RESET;
      end
    end else if (ce && seg_wr_en) begin
      seg_r[seg_wr_idx] <= seg_wr_data;
    end
  end

  // ------------------------------------------------------------
  // translation
  // ------------------------------------------------------------
  srp_xlat_if xi ();
  wire [srp_pkg::SEG_IDX_W-1:0] seg_sel = cpu_addr[srp_pkg::ADDR_W-1 -: srp_pkg::SEG_IDX_W];
  assign xi.log_addr = cpu_addr;
  assign xi.seg_reg = seg_r[seg_sel];
  assign xi.is_fetch = cpu_fetch;
  assign xi.is_write = cpu_write;
  srp_seg_xlat u_xlat (
    .x(xi)
  );

  // ------------------------------------------------------------
  // request selection
  // ------------------------------------------------------------
  // dma wins contention; the core sees a retry and reissues
  wire take_dma = dma_valid;
  wire take_cpu = cpu_valid && !dma_valid;
  wire cpu_lost = cpu_valid && dma_valid;
  // supervisor requests skip every check below
  wire cpu_xlat = take_cpu && cpu_user_mode;

  // ------------------------------------------------------------
  // fault decode
  // ------------------------------------------------------------
  // several causes may be raised by one access
  wire bad_invalid = cpu_xlat && xi.invalid;
  wire bad_exec = cpu_xlat && xi.exec_viol;
  wire bad_write = cpu_xlat && xi.write_viol;
  wire cpu_bad = bad_invalid || bad_exec || bad_write;
  wire cpu_ok = take_cpu && !cpu_bad;

  // ------------------------------------------------------------
  // memory side next values
  // ------------------------------------------------------------
  wire [srp_pkg::ADDR_W-1:0] cpu_phys = cpu_user_mode ? xi.phys_addr : cpu_addr;
  wire mem_valid_nxt = take_dma || cpu_ok;
  wire [srp_pkg::ADDR_W-1:0] mem_addr_nxt = take_dma ? dma_addr : cpu_phys;
  // write strobe stays low on a suppressed access
  wire mem_write_nxt = take_dma ? dma_write : (cpu_ok && cpu_write);
  wire [1:0] mem_src_nxt = take_dma ? srp_pkg::SRP_SRC_DMA :
                           cpu_ok ? srp_pkg::SRP_SRC_CPU : srp_pkg::SRP_SRC_NONE;

  // ------------------------------------------------------------
  // memory side registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_valid <= 1'b0;
    end else if (ce) begin
      mem_valid <= mem_valid_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr <= '0;
    end else if (ce) begin
      mem_addr <= mem_addr_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_write <= 1'b0;
    end else if (ce) begin
      mem_write <= mem_write_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_src <= srp_pkg::SRP_SRC_NONE;
    end else if (ce) begin
      mem_src <= mem_src_nxt;
    end
  end

  // ------------------------------------------------------------
  // segment readback
  // ------------------------------------------------------------
  // registered readback, one cycle behind the index
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seg_rd_data <= srp_pkg::SEG_RESET;
    end else if (ce) begin
      seg_rd_data <= seg_r[seg_rd_idx];
    end
  end

  // ------------------------------------------------------------
  // processor answer registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_retry <= 1'b0;
    end else if (ce) begin
      cpu_retry <= cpu_lost;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault <= 1'b0;
    end else if (ce) begin
      fault <= cpu_bad;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_invalid <= 1'b0;
    end else if (ce) begin
      fault_invalid <= bad_invalid;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_exec <= 1'b0;
    end else if (ce) begin
      fault_exec <= bad_exec;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_write <= 1'b0;
    end else if (ce) begin
      fault_write <= bad_write;
    end
  end

  // holds the last faulting address until the next fault
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_addr <= '0;
    end else if (ce && cpu_bad) begin
      fault_addr <= cpu_addr;
    end
  end
endmodule // srp_segment_relocation_protect
`default_nettype wire

// *** verification/srp_mem_model.sv ***
// memory side model counting accesses
`timescale 1ns/1ps
`default_nettype none
module srp_mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // memory side
  input wire logic mem_valid,
  output int hits
);
  // suppressed accesses must never reach here
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hits <= 0;
    end else if (mem_valid) begin
      hits <= hits + 1;
    end
  end
endmodule // srp_mem_model
`default_nettype wire

// *** verification/srp_chk.sv ***
// port assertions for the relocation unit
`timescale 1ns/1ps
`default_nettype none
module srp_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // processor request
  input wire logic cpu_valid,
  input wire logic [srp_pkg::ADDR_W-1:0] cpu_addr,
  input wire logic cpu_user_mode,
  // direct memory bus request
  input wire logic dma_valid,
  input wire logic [srp_pkg::ADDR_W-1:0] dma_addr,
  input wire logic dma_write,
  // memory side
  input wire logic mem_valid,
  input wire logic [srp_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_write,
  input wire logic [1:0] mem_src,
  // processor answer
  input wire logic cpu_retry,
  input wire logic fault,
  input wire logic fault_invalid,
  input wire logic fault_exec,
  input wire logic fault_write,
  input wire logic [srp_pkg::ADDR_W-1:0] fault_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_dma_path: assert property (
    dma_valid |=> mem_valid && mem_src == 2'h2 && mem_addr == $past(dma_addr) && mem_write == $past(dma_write))
    else $error("dma path wrong");
  a_cpu_retry: assert property (cpu_valid && dma_valid |=> cpu_retry && !fault)
    else $error("no retry");
  a_super_bypass: assert property (
    cpu_valid && !dma_valid && !cpu_user_mode |=> mem_valid && mem_src == 2'h1 && mem_addr == $past(cpu_addr) && !fault)
    else $error("bypass wrong");
  a_fault_supp: assert property (fault |-> !mem_valid) else $error("fault not suppressed");
  a_fault_cause: assert property (fault == (fault_invalid || fault_exec || fault_write))
    else $error("cause mismatch");
  a_fault_addr: assert property (fault |-> fault_addr == $past(cpu_addr)) else $error("fault addr");
  a_fault_hold: assert property (!fault |-> $stable(fault_addr)) else $error("fault addr moved");
  a_idle_quiet: assert property (!cpu_valid && !dma_valid |=> !mem_valid && !fault && !cpu_retry)
    else $error("spurious output");
  a_user_taken: assert property (cpu_valid && cpu_user_mode && !dma_valid |=> mem_valid != fault)
    else $error("user access lost");
endmodule // srp_chk
bind srp_segment_relocation_protect srp_chk u_srp_chk (
  .clk(clk),
  .rstn(rstn),
  .cpu_valid(cpu_valid),
  .cpu_addr(cpu_addr),
  .cpu_user_mode(cpu_user_mode),
  .dma_valid(dma_valid),
  .dma_addr(dma_addr),
  .dma_write(dma_write),
  .mem_valid(mem_valid),
  .mem_addr(mem_addr),
  .mem_write(mem_write),
  .mem_src(mem_src),
  .cpu_retry(cpu_retry),
  .fault(fault),
  .fault_invalid(fault_invalid),
  .fault_exec(fault_exec),
  .fault_write(fault_write),
  .fault_addr(fault_addr)
);
`default_nettype wire

// *** verification/srp_segment_relocation_protect_tb.sv ***
// self-checking bench for the relocation unit
`timescale 1ns/1ps
`default_nettype none
module srp_segment_relocation_protect_tb;
  logic clk = 0, rstn = 0, ce = 1, seg_wr_en = 0, cpu_valid = 0, cpu_write = 0, cpu_fetch = 0;
  logic cpu_user_mode = 0, dma_valid = 0, dma_write = 0, mem_valid, mem_write, cpu_retry;
  logic fault, fault_invalid, fault_exec, fault_write;
  logic [3:0] seg_wr_idx = 0, seg_rd_idx = 0;
  logic [31:0] seg_wr_data = 0, seg_rd_data;
  logic [19:0] cpu_addr = 0, dma_addr = 0, mem_addr, fault_addr;
  logic [1:0] mem_src;
  int fails = 0, checked = 0, cyc = 0, hits;
  always #2.5 clk = ~clk;
  srp_segment_relocation_protect u_srp_segment_relocation_protect (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .seg_wr_en(seg_wr_en),
    .seg_wr_idx(seg_wr_idx),
    .seg_wr_data(seg_wr_data),
    .seg_rd_idx(seg_rd_idx),
    .seg_rd_data(seg_rd_data),
    .cpu_valid(cpu_valid),
    .cpu_addr(cpu_addr),
    .cpu_write(cpu_write),
    .cpu_fetch(cpu_fetch),
    .cpu_user_mode(cpu_user_mode),
    .dma_valid(dma_valid),
    .dma_addr(dma_addr),
    .dma_write(dma_write),
    .mem_valid(mem_valid),
    .mem_addr(mem_addr),
    .mem_write(mem_write),
    .mem_src(mem_src),
    .cpu_retry(cpu_retry),
    .fault(fault),
    .fault_invalid(fault_invalid),
    .fault_exec(fault_exec),
    .fault_write(fault_write),
    .fault_addr(fault_addr)
  );
  srp_mem_model u_srp_mem_model (
    .clk(clk),
    .rstn(rstn),
    .mem_valid(mem_valid),
    .hits(hits)
  );
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic seg(input logic [3:0] i, input logic [31:0] d);
    @(negedge clk);
    {seg_wr_en, seg_wr_idx, seg_rd_idx, seg_wr_data} = {1'b1, i, i, d};
    @(negedge clk);
    seg_wr_en = 0;
    @(negedge clk);
    cmp(seg_rd_data, d);
  endtask
  // address of an unqualified bus is scrambled, not held
  task automatic go(input logic u, f, w, dv, input logic [19:0] a, input logic [31:0] exp);
    logic [31:0] obs;
    @(negedge clk);
    {cpu_valid, cpu_user_mode, cpu_fetch, cpu_write, dma_valid, dma_write} = {1'b1, u, f, w, dv, w};
    {cpu_addr, dma_addr} = {a, ~a};
    @(negedge clk);
    {cpu_valid, dma_valid, cpu_addr, dma_addr} = {2'h0, ~a, a};
    obs = {3'h0, mem_write, mem_valid, mem_src, cpu_retry, fault, fault_invalid, fault_exec, fault_write,
           exp[27] ? mem_addr : 20'h0};
    cmp(obs, exp);
  endtask
  // a write while enable is low must not land
  task automatic t_freeze;
    @(negedge clk);
    {ce, seg_wr_en, seg_wr_idx, seg_rd_idx, seg_wr_data} = {1'b0, 1'b1, 4'h2, 4'h2, 32'h8000_0000};
    @(negedge clk);
    {ce, seg_wr_en} = {1'b1, 1'b0};
    @(negedge clk);
    cmp(seg_rd_data, 32'h0);
  endtask
  // the model counts half a cycle after the last answer
  task automatic t_count;
    @(negedge clk);
    cmp(hits, 7);
  endtask
  task automatic t_reset;
    cmp(seg_rd_data, 32'h0);
    go(1, 0, 0, 0, 20'h30123, 32'h00c00000);
    cmp({12'h0, fault_addr}, 32'h30123);
  endtask
  task automatic t_xlat;
    seg(4'h3, 32'h80100001);
    go(1, 0, 0, 0, 20'h30123, 32'h0a001123);
    go(1, 0, 0, 0, 20'h301ff, 32'h0a0011ff);
    go(1, 0, 0, 0, 20'h30200, 32'h00c00000);
    seg(4'hf, 32'h8fff00ff);
    go(1, 0, 0, 0, 20'hfffff, 32'h0a00feff);
  endtask
  task automatic t_prot;
    seg(4'h5, 32'hc0200000);
    go(1, 1, 0, 0, 20'h50010, 32'h00a00000);
    go(1, 0, 0, 0, 20'h50010, 32'h0a002010);
    seg(4'h6, 32'ha0300000);
    go(1, 0, 1, 0, 20'h60004, 32'h00900000);
    go(1, 0, 0, 0, 20'h60004, 32'h0a003004);
  endtask
  task automatic t_bypass;
    go(0, 0, 1, 0, 20'h60004, 32'h1a060004);
    go(1, 0, 1, 1, 20'h30123, 32'h1d0cfedc);
  endtask
  task automatic complete_run;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1;
    repeat (4) @(negedge clk);
    t_reset();
    t_freeze();
    t_xlat();
    t_prot();
    t_bypass();
    t_count();
    complete_run();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      complete_run();
    end
  end
endmodule // srp_segment_relocation_protect_tb
`default_nettype wire
